// ### ws_alert_seq.sv
// windshear alert classifier, aural sequencer and alert outputs with axi4-lite registers
//
// Function
// - warning only within 0.25 nm laterally and inside heading sector
// - warning range 3 nm on ground, 1.5 nm airborne, scaled down on landing
// - no warning from 100 kt to 50 ft, below 50 ft landing, above 1200 ft
// - active warning shown on display word and hazard word
// - caution outside warning region, within 25 deg and 3 nm, on both words
// - caution suppressed like warning: takeoff window, landing below 50 ft, above 1200 ft
// - advisory within scan limit and 5 nm, display icon only, none above 1200 ft
// - warning phrase replays only for a new event with different id
// - caution aural chime, phrase or off by two bits; separate chime-off bit
// - chime sweeps 800 to 400 Hz in 300 ms, twice, 300 ms gap, twice again
// - every aural alert finishes within three seconds
// - audio silenced within 100 ms of inhibit assertion
// - inhibit flagged faulty after two minutes continuously asserted
// - pending valid alert starts audio within 500 ms of inhibit release
// - lamps and bus word levels ignore the aural inhibit; hazard word bit 8 carries the inhibit fault
// - separate warning and caution lamp outputs
// - alert-audio discrete high whenever audio plays
// - discrete leads and trails audio by 200 to 500 ms, except self-test
// - discrete rises 0 to 500 ms after level sent on hazard bus
// - hazard word sent periodically always, gaps under one second
// - each unit failure its own bit, bits 20-25 of display word
`timescale 1ns/1ns
`include "ws_defs.svh"
module ws_alert_seq
	import ws_pkg::*;
#(
	parameter int CYC_PER_MS = `WS_CYC_PER_MS,
	parameter int FAULT_MS = `WS_FAULT_MS
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic aural_inhibit_n,
	output logic warn_lamp,
	output logic caution_lamp,
	output logic alert_audio_disc,
	output logic audio_active,
	output logic tone_out,
	output logic [1:0] phrase_sel,
	output logic [31:0] display_word,
	output logic [31:0] hazard_word,
	output logic hazard_send,
	output logic inhibit_fault
);
	localparam int CHIME_MS = 5 * `WS_SWEEP_MS;
	localparam int F3_HI = 3 * `WS_F_HI_HZ;
	localparam int F3_STEP = 3 * (`WS_F_HI_HZ - `WS_F_LO_HZ) / `WS_SWEEP_MS;
	localparam int AURAL_MAX = `WS_AURAL_MAX_MS;
	localparam int GAP_MAX = `WS_HAZ_GAP_MS;
	localparam int LEAD_LO = 200;
	localparam int LEAD_HI = 500;
	// nco step per third of a hertz, tied to the tick divider so a scaled clock keeps pitch
	localparam longint NCO_K = 64'h100000000 / (64'd3000 * CYC_PER_MS);

	if (CYC_PER_MS < 2 || CYC_PER_MS >= 2**24 || FAULT_MS < 1 || FAULT_MS >= 2**18
		|| CHIME_MS > AURAL_MAX || `WS_PHRASE_MS > AURAL_MAX)
	begin : g_bad
		$error("ws_alert_seq: unsupported parameter value");
	end

	ws_flight_t flt_q;
	ws_event_t ev_q, ev_new;
	ws_level_t level_q, pend_lvl_q, play_lvl_q, prev_lvl_q, cls;
	ws_state_t st_q;
	logic [3:0] ctrl_q;
	logic [`WS_FAIL_W-1:0] fail_q;
	logic [23:0] div_q;
	logic ms_tick;
	logic aw_got_q, w_got_q, wr_go, ev_we, clr_we;
	logic [4:0] awaddr_q;
	logic [31:0] wdata_q, wm;
	logic [3:0] wstrb_q;
	logic pend_q, warn_seen_q, play_chime_q, seq_start, abort, warn_new, caut_aud;
	logic [7:0] last_id_q;
	logic [11:0] ms_q, dur_m1, sp, f3, haz_ms_q;
	logic gap, chime_on;
	logic [31:0] acc_q, inc;
	logic [17:0] inh_ms_q;

	////////////////////////////////////////////////////////////////////////
	function automatic logic map_ok(input logic [4:0] a);
		return a == `WS_A_CTRL || a == `WS_A_FLT || a == `WS_A_EVT || a == `WS_A_STAT
			|| a == `WS_A_FAIL;
	endfunction : map_ok

	function automatic logic [31:0] reg_val(input logic [4:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			`WS_A_CTRL: v = {28'h0, ctrl_q};
			`WS_A_FLT: v = {8'h0, flt_q};
			`WS_A_EVT: v = ev_q;
			`WS_A_STAT: v = {24'h0, inhibit_fault, alert_audio_disc, audio_active, pend_q,
				st_q, level_q};
			`WS_A_FAIL: v = {26'h0, fail_q};
			default: v = 32'h0;
		endcase
		return v;
	endfunction : reg_val

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[8*i +: 8] = d[8*i +: 8];
		return o;
	endfunction : wmerge

	function automatic ws_level_t classify(input ws_event_t e, input ws_flight_t f);
		logic [7:0] lim;
		logic [11:0] land;
		logic sup;
		lim = f.on_ground ? `WS_RNG_GND : `WS_RNG_AIR;
		land = f.alt_ft / `WS_LAND_FT;
		if (f.landing && land < {4'h0, lim})
			lim = land[7:0];
		sup = f.alt_ft > `WS_ALT_HI || (f.landing && f.alt_ft < `WS_ALT_LO)
			|| (f.takeoff && f.speed_kt >= `WS_SPD_TO && f.alt_ft < `WS_ALT_LO);
		if (e.lat <= `WS_LAT_WARN && e.hdg_deg <= `WS_HDG_SECT && e.range <= lim)
			return sup ? LV_NONE : LV_WARN;
		if (e.hdg_deg <= `WS_HDG_SECT && e.range <= `WS_RNG_CAUT)
			return sup ? LV_NONE : LV_CAUT;
		if (e.hdg_deg <= `WS_SCAN_DEG && e.range <= `WS_RNG_ADV && f.alt_ft <= `WS_ALT_HI)
			return LV_ADV;
		return LV_NONE;
	endfunction : classify

	////////////////////////////////////////////////////////////////////////
	// millisecond enable
	assign ms_tick = div_q == 24'(CYC_PER_MS - 1);

	always_ff @(posedge aclk)
		if (!aresetn || ms_tick)
			div_q <= 24'h0;
		else
			div_q <= div_q + 24'h1;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write and read channels
	assign awready = !aw_got_q && !bvalid;
	assign wready = !w_got_q && !bvalid;
	assign arready = !rvalid;
	assign wr_go = aw_got_q && w_got_q && !bvalid;
	// process form so that register changes read inside reg_val retrigger the merge
	always_comb
		wm = wmerge(reg_val(awaddr_q), wdata_q, wstrb_q);
	assign ev_we = wr_go && awaddr_q == `WS_A_EVT;
	assign clr_we = wr_go && awaddr_q == `WS_A_CTRL && wstrb_q[0] && wdata_q[`WS_C_CLR];
	assign ev_new = ws_event_t'(wm);
	assign cls = classify(ev_new, flt_q);

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 5'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_go)
			begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= map_ok(awaddr_q) ? 2'b00 : 2'b10;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'b00;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata <= reg_val(araddr);
			rresp <= map_ok(araddr) ? 2'b00 : 2'b10;
		end
		else if (rready)
			rvalid <= 1'b0;

	// status reads ignore writes; flight data is not re-evaluated against old events
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			ctrl_q <= `WS_CTRL_RST;
			flt_q <= '0;
			ev_q <= '0;
			fail_q <= '0;
		end
		else if (wr_go)
			case (awaddr_q)
				`WS_A_CTRL: ctrl_q <= wm[3:0];
				`WS_A_FLT: flt_q <= ws_flight_t'(wm[23:0]);
				`WS_A_EVT: ev_q <= ev_new;
				`WS_A_FAIL: fail_q <= wm[`WS_FAIL_W-1:0];
				default: ;
			endcase

	////////////////////////////////////////////////////////////////////////
	// alert level and aural requests
	always_ff @(posedge aclk)
		if (!aresetn)
			level_q <= LV_NONE;
		else if (ev_we)
			level_q <= cls;
		else if (clr_we)
			level_q <= LV_NONE;

	assign caut_aud = ws_csel_t'(ctrl_q[1:0]) == CS_PHRASE
		|| (ws_csel_t'(ctrl_q[1:0]) == CS_CHIME && !ctrl_q[`WS_C_CHOFF]);
	assign warn_new = cls == LV_WARN && (!warn_seen_q || ev_new.id != last_id_q);
	assign seq_start = pend_q && aural_inhibit_n && level_q >= pend_lvl_q
		&& (st_q == ST_IDLE || st_q == ST_HOLD);
	assign abort = !aural_inhibit_n && (st_q == ST_LEAD || st_q == ST_PLAY);

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			last_id_q <= 8'h00;
			warn_seen_q <= 1'b0;
		end
		else if (ev_we && cls == LV_WARN)
		begin
			last_id_q <= ev_new.id;
			warn_seen_q <= 1'b1;
		end

	// later assignments win: a new event overrides the drop of a stale request
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			pend_q <= 1'b0;
			pend_lvl_q <= LV_NONE;
		end
		else
		begin
			if (pend_q && level_q < pend_lvl_q)
				pend_q <= 1'b0;
			if (seq_start)
				pend_q <= 1'b0;
			if (abort)
			begin
				pend_q <= 1'b1;
				pend_lvl_q <= play_lvl_q;
			end
			if (ev_we && warn_new)
			begin
				pend_q <= 1'b1;
				pend_lvl_q <= LV_WARN;
			end
			else if (ev_we && cls == LV_CAUT && level_q != LV_CAUT && caut_aud
				&& !(pend_q && pend_lvl_q == LV_WARN))
			begin
				pend_q <= 1'b1;
				pend_lvl_q <= LV_CAUT;
			end
		end

	////////////////////////////////////////////////////////////////////////
	// aural sequencer
	assign dur_m1 = play_chime_q ? 12'(CHIME_MS - 1) : 12'(`WS_PHRASE_MS - 1);

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			st_q <= ST_IDLE;
			ms_q <= 12'h000;
			play_lvl_q <= LV_NONE;
			play_chime_q <= 1'b0;
		end
		else if (seq_start)
		begin
			st_q <= ST_LEAD;
			ms_q <= 12'h000;
			play_lvl_q <= pend_lvl_q;
			play_chime_q <= pend_lvl_q == LV_CAUT && ws_csel_t'(ctrl_q[1:0]) == CS_CHIME;
		end
		else
			unique case (st_q)
				ST_IDLE: ;
				ST_LEAD:
					if (abort)
					begin
						st_q <= ST_HOLD;
						ms_q <= 12'h000;
					end
					else if (ctrl_q[`WS_C_TEST] || (ms_tick && ms_q == 12'(`WS_LEAD_MS - 1)))
					begin
						st_q <= ST_PLAY;
						ms_q <= 12'h000;
					end
					else if (ms_tick)
						ms_q <= ms_q + 12'h001;
				ST_PLAY:
					if (abort || (ms_tick && ms_q == dur_m1))
					begin
						st_q <= (ctrl_q[`WS_C_TEST] && !abort) ? ST_IDLE : ST_HOLD;
						ms_q <= 12'h000;
					end
					else if (ms_tick)
						ms_q <= ms_q + 12'h001;
				ST_HOLD:
					if (ctrl_q[`WS_C_TEST] || (ms_tick && ms_q == 12'(`WS_HOLD_MS - 1)))
						st_q <= ST_IDLE;
					else if (ms_tick)
						ms_q <= ms_q + 12'h001;
			endcase

	// chime: sweep position within the 5-slot pattern, slot 2 is the gap
	always_comb
	begin
		gap = 1'b0;
		sp = ms_q;
		if (ms_q >= 12'(4 * `WS_SWEEP_MS))
			sp = ms_q - 12'(4 * `WS_SWEEP_MS);
		else if (ms_q >= 12'(3 * `WS_SWEEP_MS))
			sp = ms_q - 12'(3 * `WS_SWEEP_MS);
		else if (ms_q >= 12'(2 * `WS_SWEEP_MS))
		begin
			sp = 12'h000;
			gap = 1'b1;
		end
		else if (ms_q >= 12'(`WS_SWEEP_MS))
			sp = ms_q - 12'(`WS_SWEEP_MS);
	end

	// frequency in thirds of a hertz steps down linearly each ms; nco constant truncates ~1 %
	assign f3 = 12'(F3_HI) - 12'(sp * F3_STEP);
	assign inc = 32'(f3 * NCO_K);
	assign chime_on = st_q == ST_PLAY && play_chime_q && !gap;

	always_ff @(posedge aclk)
		if (!aresetn || !chime_on)
			acc_q <= 32'h0;
		else
			acc_q <= acc_q + inc;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			tone_out <= 1'b0;
			audio_active <= 1'b0;
			alert_audio_disc <= 1'b0;
			phrase_sel <= 2'b00;
		end
		else
		begin
			tone_out <= chime_on && acc_q[31];
			audio_active <= st_q == ST_PLAY;
			alert_audio_disc <= st_q != ST_IDLE;
			phrase_sel <= (st_q == ST_PLAY && !play_chime_q)
				? ((play_lvl_q == LV_WARN) ? 2'b01 : 2'b10) : 2'b00;
		end

	////////////////////////////////////////////////////////////////////////
	// lamps, bus words, inhibit monitor
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			warn_lamp <= 1'b0;
			caution_lamp <= 1'b0;
			display_word <= 32'h0;
			hazard_word <= 32'h0;
		end
		else
		begin
			warn_lamp <= level_q == LV_WARN;
			caution_lamp <= level_q == LV_CAUT;
			display_word <= {6'h00, fail_q, 15'h0000, level_q == LV_CAUT, level_q == LV_WARN,
				level_q == LV_ADV, level_q};
			hazard_word <= {23'h0, inhibit_fault, fail_q, level_q == LV_ADV ? LV_NONE : level_q};
		end

	// periodic send never depends on mode, a level change is sent at once
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			haz_ms_q <= 12'h000;
			hazard_send <= 1'b0;
			prev_lvl_q <= LV_NONE;
		end
		else
		begin
			prev_lvl_q <= level_q;
			hazard_send <= (ms_tick && haz_ms_q == 12'(`WS_HAZ_MS - 1)) || level_q != prev_lvl_q;
			if (ms_tick)
				haz_ms_q <= (haz_ms_q == 12'(`WS_HAZ_MS - 1)) ? 12'h000 : haz_ms_q + 12'h001;
		end

	always_ff @(posedge aclk)
		if (!aresetn || aural_inhibit_n)
		begin
			inh_ms_q <= 18'h0;
			inhibit_fault <= 1'b0;
		end
		else
		begin
			if (ms_tick && inh_ms_q < 18'(FAULT_MS))
				inh_ms_q <= inh_ms_q + 18'h1;
			inhibit_fault <= inh_ms_q >= 18'(FAULT_MS);
		end

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [11:0] lead_ms_hq, play_ms_hq, gap_ms_hq;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			lead_ms_hq <= 12'h000;
			play_ms_hq <= 12'h000;
			gap_ms_hq <= 12'h000;
		end
		else
		begin
			lead_ms_hq <= (st_q != ST_LEAD) ? 12'h000 : lead_ms_hq + 12'(ms_tick);
			play_ms_hq <= (st_q != ST_PLAY) ? 12'h000 : play_ms_hq + 12'(ms_tick);
			gap_ms_hq <= hazard_send ? 12'h000 : gap_ms_hq + 12'(ms_tick);
		end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_LAMPS_ONEHOT: assert property (!(warn_lamp && caution_lamp))
		else $error("both lamps lit");
	AST_NO_ALERT_HIGH: assert property (ev_we && flt_q.alt_ft > `WS_ALT_HI
		|=> level_q == LV_NONE) else $error("alert above 1200 ft");
	AST_WARN_LATERAL: assert property (ev_we && ev_new.lat > `WS_LAT_WARN
		|=> level_q != LV_WARN) else $error("warning outside lateral band");
	AST_WARN_AIR_RANGE: assert property (ev_we && !flt_q.on_ground
		&& ev_new.range > `WS_RNG_AIR |=> level_q != LV_WARN) else $error("air warning range");
	AST_CAUT_RANGE: assert property (ev_we && ev_new.range > `WS_RNG_CAUT
		|=> level_q inside {LV_NONE, LV_ADV}) else $error("caution beyond range");
	AST_TAKEOFF_SUPP: assert property (ev_we && flt_q.takeoff
		&& flt_q.speed_kt >= `WS_SPD_TO && flt_q.alt_ft < `WS_ALT_LO
		|=> !(level_q inside {LV_CAUT, LV_WARN})) else $error("takeoff alert not suppressed");
	AST_DISP_LEVEL: assert property (level_q == LV_WARN [*2]
		|-> display_word[1:0] == 2'b11 && hazard_word[1:0] == 2'b11) else $error("warn not sent");
	AST_AUDIO_DISC: assert property (audio_active |-> alert_audio_disc)
		else $error("audio without discrete");
	AST_INHIBIT_SILENCE: assert property (!aural_inhibit_n && st_q == ST_PLAY
		|=> st_q == ST_HOLD ##1 !audio_active) else $error("inhibit not obeyed");
	AST_LEAD_TIME: assert property (st_q == ST_LEAD && !ctrl_q[`WS_C_TEST]
		##1 st_q == ST_PLAY |-> lead_ms_hq >= LEAD_LO && lead_ms_hq <= LEAD_HI)
		else $error("discrete lead time");
	AST_AURAL_MAX: assert property (play_ms_hq <= AURAL_MAX)
		else $error("aural alert too long");
	AST_HAZ_GAP: assert property (gap_ms_hq <= GAP_MAX)
		else $error("hazard bus gap");
	AST_FAULT_CAUSE: assert property ($rose(inhibit_fault) |-> $past(!aural_inhibit_n, 2)
		&& inh_ms_q >= 18'(FAULT_MS)) else $error("fault without inhibit");
	AST_RELEASE_START: assert property (seq_start |=> st_q == ST_LEAD
		##1 alert_audio_disc) else $error("no start after release");
	AST_DISC_AFTER_HAZ: assert property ($rose(alert_audio_disc)
		|-> $past(hazard_send, 1) || hazard_word[1:0] != 2'b00) else $error("disc before hazard");

	COV_WARN_PHRASE: cover property (phrase_sel == 2'b01);
	COV_CHIME: cover property (tone_out && play_lvl_q == LV_CAUT);
	COV_FAULT: cover property ($rose(inhibit_fault));
	COV_ABORT: cover property (abort ##1 st_q == ST_HOLD);
endmodule : ws_alert_seq

// ### ws_defs.svh
// offsets, field positions, reset values and timing constants of the windshear alert block
`ifndef WS_DEFS_SVH
`define WS_DEFS_SVH
`define WS_CLK_HZ 20000000
`define WS_CYC_PER_MS (`WS_CLK_HZ / 1000)
`define WS_A_CTRL 5'h00
`define WS_A_FLT 5'h04
`define WS_A_EVT 5'h08
`define WS_A_STAT 5'h0c
`define WS_A_FAIL 5'h10
`define WS_CTRL_RST 4'h0
`define WS_C_CHOFF 2
`define WS_C_TEST 3
`define WS_C_CLR 4
`define WS_FAIL_W 6
`define WS_LAT_WARN 8'h19
`define WS_HDG_SECT 8'h19
`define WS_SCAN_DEG 8'h28
`define WS_RNG_GND 8'h1e
`define WS_RNG_AIR 8'h0f
`define WS_RNG_CAUT 8'h1e
`define WS_RNG_ADV 8'h32
`define WS_LAND_FT 12'h014
`define WS_SPD_TO 9'h064
`define WS_ALT_LO 12'h032
`define WS_ALT_HI 12'h4b0
`define WS_LEAD_MS 300
`define WS_HOLD_MS 300
`define WS_SWEEP_MS 300
`define WS_PHRASE_MS 2400
`define WS_AURAL_MAX_MS 3000
`define WS_FAULT_S 120
`define WS_FAULT_MS (`WS_FAULT_S * 1000)
`define WS_HAZ_MS 100
`define WS_HAZ_GAP_MS 1000
`define WS_F_HI_HZ 800
`define WS_F_LO_HZ 400
`endif

// ### ws_pkg.sv
// types of the windshear alert block
package ws_pkg;
	typedef enum logic [1:0] {LV_NONE = 2'b00, LV_ADV = 2'b01, LV_CAUT = 2'b10,
		LV_WARN = 2'b11} ws_level_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LEAD = 2'b01, ST_PLAY = 2'b10,
		ST_HOLD = 2'b11} ws_state_t;
	typedef enum logic [1:0] {CS_CHIME = 2'b00, CS_PHRASE = 2'b01, CS_OFF = 2'b10,
		CS_OFF2 = 2'b11} ws_csel_t;
	typedef struct packed {
		logic landing;
		logic takeoff;
		logic on_ground;
		logic [8:0] speed_kt;
		logic [11:0] alt_ft;
	} ws_flight_t;
	typedef struct packed {
		logic [7:0] id;
		logic [7:0] range;
		logic [7:0] hdg_deg;
		logic [7:0] lat;
	} ws_event_t;
endpackage : ws_pkg

// ### ws_cockpit_model.sv
// far-side model: display and avionics units watching the alert outputs
`timescale 1ns/1ns
module ws_cockpit_model
	import ws_pkg::*;
#(
	parameter int GAP_MAX = 10000
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] display_word,
	input wire logic hazard_send,
	input wire logic audio_active,
	input wire logic alert_audio_disc,
	output logic sys_fail,
	output logic bad_seen
);
	int gap_q;
	// the display shows one flag for any failed unit
	assign sys_fail = |display_word[25:20];
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gap_q <= 0;
			bad_seen <= 1'b0;
		end
		else
		begin
			gap_q <= hazard_send ? 0 : gap_q + 1;
			if (gap_q > GAP_MAX)
				bad_seen <= 1'b1;
			// other units rely on the discrete to mute their own aural alerts
			if (audio_active && !alert_audio_disc)
				bad_seen <= 1'b1;
		end
	end
endmodule : ws_cockpit_model

// ### windshear_alert_sequencer_tb.sv
// self-checking bench of the windshear alert sequencer
`timescale 1ns/1ns
`include "ws_defs.svh"
`define CHK(nm, ex, gt) \
	begin \
		total_checks++; \
		if ((gt) !== (ex)) \
		begin \
			failures++; \
			$display("Error %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module windshear_alert_sequencer_tb
	import ws_pkg::*;
;
	localparam int MS = 10;
	typedef struct packed {
		ws_flight_t f;
		logic [7:0] lat;
		logic [7:0] hdg;
		logic [7:0] rng;
		ws_level_t lv;
	} ws_row_t;
	localparam ws_flight_t F_AIR = '{1'b0, 1'b0, 1'b0, 9'h096, 12'h1f4};
	localparam ws_flight_t F_GND = '{1'b0, 1'b0, 1'b1, 9'h000, 12'h000};
	localparam ws_row_t ROWS [0:16] = '{
		'{F_AIR, 8'h19, 8'h19, 8'h0f, LV_WARN},
		'{F_AIR, 8'h19, 8'h19, 8'h10, LV_CAUT},
		'{F_AIR, 8'h1a, 8'h19, 8'h0a, LV_CAUT},
		'{F_AIR, 8'h00, 8'h1a, 8'h0a, LV_ADV},
		'{F_GND, 8'h00, 8'h00, 8'h1e, LV_WARN},
		'{F_GND, 8'h00, 8'h00, 8'h1f, LV_ADV},
		'{'{1'b0, 1'b0, 1'b0, 9'h096, 12'h4b1}, 8'h00, 8'h00, 8'h0a, LV_NONE},
		'{'{1'b0, 1'b0, 1'b0, 9'h096, 12'h4b0}, 8'h00, 8'h00, 8'h0a, LV_WARN},
		'{'{1'b0, 1'b1, 1'b0, 9'h064, 12'h031}, 8'h00, 8'h00, 8'h0a, LV_NONE},
		'{'{1'b0, 1'b1, 1'b0, 9'h063, 12'h031}, 8'h00, 8'h00, 8'h0a, LV_WARN},
		'{'{1'b1, 1'b0, 1'b0, 9'h096, 12'h031}, 8'h00, 8'h00, 8'h0a, LV_NONE},
		'{'{1'b1, 1'b0, 1'b0, 9'h096, 12'h0c8}, 8'h00, 8'h00, 8'h0b, LV_CAUT},
		'{'{1'b1, 1'b0, 1'b0, 9'h096, 12'h0c8}, 8'h00, 8'h00, 8'h0a, LV_WARN},
		'{F_AIR, 8'h00, 8'h28, 8'h32, LV_ADV},
		'{F_AIR, 8'h00, 8'h29, 8'h0a, LV_NONE},
		'{F_AIR, 8'h00, 8'h1e, 8'h33, LV_NONE},
		'{'{1'b0, 1'b0, 1'b0, 9'h096, 12'h4b1}, 8'h00, 8'h1e, 8'h0a, LV_NONE}
	};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, aural_inhibit_n, warn_lamp, caution_lamp;
	logic alert_audio_disc, audio_active, tone_out, hazard_send, inhibit_fault;
	logic sys_fail, bad_seen;
	logic [4:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, phrase_sel;
	logic [31:0] wdata, rdata, display_word, hazard_word;
	int failures, total_checks;
	ws_alert_seq #(.CYC_PER_MS(MS), .FAULT_MS(50)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .aural_inhibit_n(aural_inhibit_n),
		.warn_lamp(warn_lamp), .caution_lamp(caution_lamp), .alert_audio_disc(alert_audio_disc),
		.audio_active(audio_active), .tone_out(tone_out), .phrase_sel(phrase_sel),
		.display_word(display_word), .hazard_word(hazard_word), .hazard_send(hazard_send),
		.inhibit_fault(inhibit_fault));
	ws_cockpit_model #(.GAP_MAX(1000 * MS)) i_model (.aclk(aclk), .aresetn(aresetn),
		.display_word(display_word), .hazard_send(hazard_send), .audio_active(audio_active),
		.alert_audio_disc(alert_audio_disc), .sys_fail(sys_fail), .bad_seen(bad_seen));
	always #25 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			aw_done = aw_done || (awvalid && awready);
			w_done = w_done || (wvalid && wready);
			awvalid <= !aw_done;
			wvalid <= !w_done;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		`CHK("bresp", er, bresp)
	endtask : axw
	task automatic rchk(string nm, logic [4:0] a, logic [31:0] m, logic [31:0] ex,
		logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		`CHK(nm, ex, rdata & m)
		`CHK("rresp", er, rresp)
	endtask : rchk
	task automatic till(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v)
		begin
			@(posedge aclk);
			n++;
		end
	endtask : till
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rchk("ctrl_rst", `WS_A_CTRL, 32'hffffffff, 32'h0, 2'b00);
		axw(`WS_A_CTRL, 32'h1f, 2'b00);
		rchk("ctrl", `WS_A_CTRL, 32'hff, 32'h0f, 2'b00);
		axw(`WS_A_STAT, 32'hff, 2'b00);
		rchk("stat", `WS_A_STAT, 32'hff, 32'h0, 2'b00);
		axw(5'h14, 32'h1, 2'b10);
		rchk("unmapped", 5'h14, 32'hffffffff, 32'h0, 2'b10);
		axw(`WS_A_FLT, 32'h00ffffff, 2'b00);
		wstrb <= 4'h2;
		axw(`WS_A_FLT, 32'h0, 2'b00);
		wstrb <= 4'hf;
		rchk("strobe", `WS_A_FLT, 32'hffffffff, 32'h00ff00ff, 2'b00);
		axw(`WS_A_FAIL, 32'h21, 2'b00);
		repeat (3) @(posedge aclk);
		`CHK("disp_fail", 6'h21, display_word[25:20])
		`CHK("haz_fail", 6'h21, hazard_word[7:2])
		`CHK("sys_fail", 1'b1, sys_fail)
		axw(`WS_A_FAIL, 32'h0, 2'b00);
		axw(`WS_A_CTRL, 32'h2, 2'b00);
	endtask : t_regs
	task automatic t_warn();
		int n;
		axw(`WS_A_FLT, 32'(F_AIR), 2'b00);
		axw(`WS_A_EVT, {8'h11, 8'h0f, 8'h19, 8'h19}, 2'b00);
		till(alert_audio_disc, 1'b1, n);
		`CHK("disc_delay", 1'b1, n <= 500 * MS)
		`CHK("haz_level", LV_WARN, hazard_word[1:0])
		`CHK("disp_level", LV_WARN, display_word[1:0])
		till(audio_active, 1'b1, n);
		`CHK("lead", 1'b1, n >= 200 * MS && n <= 500 * MS)
		`CHK("phrase", 2'b01, phrase_sel)
		till(audio_active, 1'b0, n);
		`CHK("play_len", 1'b1, n <= 3000 * MS)
		till(alert_audio_disc, 1'b0, n);
		`CHK("hold", 1'b1, n >= 200 * MS && n <= 500 * MS)
	endtask : t_warn
	task automatic t_table();
		// same event id throughout, so no warning may replay; caution aural is off
		for (int i = 0; i < 17; i++)
		begin
			axw(`WS_A_FLT, 32'(ROWS[i].f), 2'b00);
			axw(`WS_A_EVT, {8'h11, ROWS[i].rng, ROWS[i].hdg, ROWS[i].lat}, 2'b00);
			repeat (3) @(posedge aclk);
			`CHK("lamp_w", ROWS[i].lv == LV_WARN, warn_lamp)
			`CHK("lamp_c", ROWS[i].lv == LV_CAUT, caution_lamp)
			`CHK("disp_lv", ROWS[i].lv, display_word[1:0])
			`CHK("icon", ROWS[i].lv == LV_ADV, display_word[2])
			`CHK("haz_lv", ROWS[i].lv == LV_ADV ? LV_NONE : ROWS[i].lv, hazard_word[1:0])
			`CHK("replay", 1'b0, alert_audio_disc)
		end
	endtask : t_table
	task automatic t_chime();
		int n, tg_a, tg_b;
		logic last;
		tg_a = 0;
		tg_b = 0;
		axw(`WS_A_FLT, 32'(F_AIR), 2'b00);
		axw(`WS_A_CTRL, 32'h14, 2'b00);
		axw(`WS_A_EVT, {8'h12, 8'h14, 8'h00, 8'h1a}, 2'b00);
		repeat (200) @(posedge aclk);
		`CHK("chime_off", 1'b0, alert_audio_disc)
		// self-test on: lead shrinks to a cycle and hold is skipped
		axw(`WS_A_CTRL, 32'h18, 2'b00);
		axw(`WS_A_EVT, {8'h12, 8'h14, 8'h00, 8'h1a}, 2'b00);
		till(audio_active, 1'b1, n);
		`CHK("test_lead", 1'b1, n < 200 * MS)
		`CHK("chime_sel", 2'b00, phrase_sel)
		last = tone_out;
		// skip the edges of the gap to stay clear of sweep boundaries
		for (int c = 0; c < 900 * MS; c++)
		begin
			@(posedge aclk);
			if (c < 300 * MS)
				tg_a += int'(tone_out !== last);
			else if (c >= 620 * MS && c < 880 * MS)
				tg_b += int'(tone_out !== last);
			last = tone_out;
		end
		`CHK("sweep", 1'b1, tg_a > 0)
		`CHK("gap", 0, tg_b)
		till(audio_active, 1'b0, n);
		`CHK("chime_len", 1'b1, n >= 550 * MS && n <= 650 * MS)
		till(alert_audio_disc, 1'b0, n);
		`CHK("test_hold", 1'b1, n < 200 * MS)
	endtask : t_chime
	task automatic t_inhib();
		int n;
		axw(`WS_A_CTRL, 32'h11, 2'b00);
		aural_inhibit_n <= 1'b0;
		axw(`WS_A_EVT, {8'h13, 8'h14, 8'h00, 8'h1a}, 2'b00);
		repeat (400) @(posedge aclk);
		`CHK("fault_early", 1'b0, inhibit_fault)
		repeat (200) @(posedge aclk);
		`CHK("fault", 1'b1, inhibit_fault)
		`CHK("haz_fault", 1'b1, hazard_word[8])
		`CHK("lamp_inh", 1'b1, caution_lamp)
		`CHK("haz_inh", LV_CAUT, hazard_word[1:0])
		`CHK("muted", 1'b0, audio_active)
		aural_inhibit_n <= 1'b1;
		till(audio_active, 1'b1, n);
		`CHK("release", 1'b1, n <= 500 * MS)
		`CHK("fault_clr", 1'b0, inhibit_fault)
		`CHK("caut_phrase", 2'b10, phrase_sel)
		aural_inhibit_n <= 1'b0;
		till(audio_active, 1'b0, n);
		`CHK("silence", 1'b1, n <= 100 * MS)
		`CHK("lamp_keep", 1'b1, caution_lamp)
	endtask : t_inhib
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(64'd90000 * 50);
		failures++;
		summarize();
	end
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		// responses are always accepted, so bready and rready stay high
		{awvalid, wvalid, bready, arvalid, rready} = 5'h05;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		aural_inhibit_n = 1'b1;
		failures = 0;
		total_checks = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_warn();
		t_table();
		t_chime();
		t_inhib();
		`CHK("model", 1'b0, bad_seen)
		summarize();
	end
endmodule : windshear_alert_sequencer_tb
